/* File: verilog/pcierx_core.sv */
// Purpose: receive TLP delivery to user logic and UpdateFC scheduling
// Assumes: link-side stream and user logic both run on hclk
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// Behaviour
// [R01] start flag on first beat of TLP
// [R02] end flag on final beat of TLP
// [R03] half flag when only [63:32] valid
// [R04] ECRC error flag only when checking enabled
// [R05] locked read flagged unsupported, still forwarded
// [R06] user completes flagged TLP with UR status
// [R07] malformed flag on bad length or format
// [R08] seven-bit window hit vector, bit6 ROM
// [R09] 64-bit window hits shown on lower slot
// [R10] hit vector changes with start flag
// [R11] user reports unsupported non-posted requests
// [R12] user reports unsupported posted requests
// [R13] buffer full forces early UpdateFC
// [R14] each high header cycle is one credit
// [R15] UpdateFC on timer expiry or enough credits
// [R16] data credits: count plus one-cycle strobe
// [R17] earliest byte in bits 63 to 56
// [R18] error flags held from start to end
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps

module pcierx_core
  import pcierx_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic                      irq,
  // link-side received stream
  input  wire logic                 lnk_valid,
  input  wire logic                 lnk_sop,
  input  wire logic                 lnk_eop,
  input  wire logic                 lnk_dwen,
  input  wire logic [DATA_W-1:0]    lnk_data,
  input  wire logic                 lnk_ecrc_bad,
  input  wire logic                 lnk_malformed,
  input  wire logic                 lnk_locked_read,
  input  wire logic [BAR_W-1:0]     lnk_bar_hit,
  // user receive side
  output logic                      rx_beat_valid,
  output logic                      rx_packet_first_beat,
  output logic                      rx_packet_last_beat,
  output logic                      rx_upper_half_only,
  output logic [DATA_W-1:0]         rx_payload_bus,
  output logic                      rx_end_to_end_crc_fail,
  output logic                      rx_unsupported_flag,
  output logic                      rx_malformed_flag,
  output logic [BAR_W-1:0]          rx_bar_hit,
  // user credit return
  input  wire logic                 user_unsupported_nonposted,
  input  wire logic                 user_unsupported_posted,
  input  wire logic [NTYPE-1:0]     user_buffer_full,
  input  wire logic [1:0]           header_credit_returned,
  input  wire logic [1:0]           data_credit_return_strobe,
  input  wire logic [NUM_W-1:0]     data_credit_return_count_p,
  input  wire logic [NUM_W-1:0]     data_credit_return_count_np,
  // updatefc request to link layer
  output logic                      updfc_valid,
  output logic [1:0]                updfc_type,
  output logic [CRED_W-1:0]         updfc_credits
);

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction : reg_hit

  // fold the upper half of each 64-bit window pair into its lower slot
  function automatic logic [BAR_W-1:0] fold_bar(input logic [BAR_W-1:0] hit,
                                                input logic [2:0]       is64);
    logic [BAR_W-1:0] r;
    r = hit;
    for (int k = 0; k < 3; k++) begin
      if (is64[k]) begin
        r[2*k]   = hit[2*k] | hit[2*k+1];
        r[2*k+1] = 1'b0;
      end
    end
    fold_bar = r;
  endfunction : fold_bar

  function automatic logic [1:0] pick(input logic [NTYPE-1:0] req);
    logic [1:0] r;
    r = 2'h0;
    for (int k = NTYPE - 1; k >= 0; k--) begin
      if (req[k]) begin
        r = 2'(k);
      end
    end
    pick = r;
  endfunction : pick

  // ---------------- register bus ----------------
  // write data lands one cycle after its address phase, so the decode uses the held address
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic [CTRL_W-1:0]    ctrl;
  logic [STAT_W-1:0]    stat;
  logic [STAT_W-1:0]    mask;
  logic [TMR_W-1:0]     upd_limit;
  logic [NUM_W-1:0]     thresh;
  logic [CRED_W-1:0]    pend [NTYPE];

  wire                  acc        = hsel & hready & htrans[1];
  wire                  rd_acc     = acc & ~hwrite;
  wire  [7:0]           ra         = haddr[7:0];
  wire                  w_ctrl     = wr_pend & reg_hit(wr_addr, OFF_CTRL);
  wire                  w_stat     = wr_pend & reg_hit(wr_addr, OFF_STAT);
  wire                  w_mask     = wr_pend & reg_hit(wr_addr, OFF_MASK);
  wire                  w_timer    = wr_pend & reg_hit(wr_addr, OFF_TIMER);
  wire                  w_thresh   = wr_pend & reg_hit(wr_addr, OFF_THRESH);
  wire  [STAT_W-1:0]    w1c        = w_stat ? hwdata[STAT_W-1:0] : '0;
  wire  [31:0]          hcred_word = {4'h0, pend[TY_NPH], 4'h0, pend[TY_PH]};
  wire  [31:0]          dcred_word = {4'h0, pend[TY_NPD], 4'h0, pend[TY_PD]};
  wire  [31:0]          next_hrdata =
      !rd_acc                     ? 32'h0000_0000 :
      reg_hit(ra, OFF_CTRL)       ? {28'h0, ctrl} :
      reg_hit(ra, OFF_STAT)       ? {26'h0, stat} :
      reg_hit(ra, OFF_MASK)       ? {26'h0, mask} :
      reg_hit(ra, OFF_TIMER)      ? {16'h0, upd_limit} :
      reg_hit(ra, OFF_THRESH)     ? {24'h0, thresh} :
      reg_hit(ra, OFF_HCRED)      ? hcred_word :
      reg_hit(ra, OFF_DCRED)      ? dcred_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend   <= acc & hwrite;
      wr_addr   <= haddr[7:0];
      hrdata    <= next_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= CTRL_RST;
      mask      <= MASK_RST;
      upd_limit <= TIMER_RST;
      thresh    <= THRESH_RST;
    end else if (ce) begin
      if (w_ctrl)   ctrl      <= hwdata[CTRL_W-1:0];
      if (w_mask)   mask      <= hwdata[STAT_W-1:0];
      if (w_timer)  upd_limit <= hwdata[TMR_W-1:0];
      if (w_thresh) thresh    <= hwdata[NUM_W-1:0];
    end
  end

  // ---------------- receive path ----------------
  wire                  ecrc_on   = ctrl[CTRL_ECRC_BIT];
  wire  [2:0]           bar64     = ctrl[CTRL_BAR64_LSB +: 3];
  wire                  beat      = lnk_valid;
  wire                  first     = lnk_valid & lnk_sop;
  wire                  last      = lnk_valid & lnk_eop;
  // [R18] flags restart at start, accumulate to end
  wire                  next_ecrc = (first ? 1'b0 : rx_end_to_end_crc_fail)
                                    | (lnk_ecrc_bad & ecrc_on);
  wire                  next_ur   = (first ? 1'b0 : rx_unsupported_flag) | lnk_locked_read;
  wire                  next_malf = (first ? 1'b0 : rx_malformed_flag) | lnk_malformed;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_beat_valid        <= 1'b0;
      rx_packet_first_beat <= 1'b0;
      rx_packet_last_beat  <= 1'b0;
      rx_upper_half_only   <= 1'b0;
      rx_payload_bus       <= '0;
    end else if (ce) begin
      rx_beat_valid        <= beat;
      // [R01] start on first beat
      rx_packet_first_beat <= first;
      // [R02] end on final beat
      rx_packet_last_beat  <= last;
      // [R03] upper word only
      rx_upper_half_only   <= beat & lnk_dwen;
      // [R17] byte order kept, earliest in 63:56
      if (beat) rx_payload_bus <= lnk_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_end_to_end_crc_fail <= 1'b0;
      rx_unsupported_flag    <= 1'b0;
      rx_malformed_flag      <= 1'b0;
      rx_bar_hit             <= '0;
    end else if (ce && beat) begin
      // [R04] gated by ecrc enable
      rx_end_to_end_crc_fail <= next_ecrc;
      // [R05] locked read flagged, still passed on
      rx_unsupported_flag    <= next_ur;
      // [R07] malformed indication
      rx_malformed_flag      <= next_malf;
      // [R10] hit vector loads with start
      // [R08] [R09] folded hit vector
      if (lnk_sop) rx_bar_hit <= fold_bar(lnk_bar_hit, bar64);
    end
  end

  // ---------------- credit return and updatefc ----------------
  logic [NTYPE-1:0]     req;
  logic [NTYPE-1:0]     full_req;
  logic [NTYPE-1:0]     full_q;
  logic [CRED_W-1:0]    add [NTYPE];
  logic [TMR_W-1:0]     tmr [NTYPE];
  wire                  fire  = |req;
  wire  [1:0]           gidx  = pick(req);

  genvar t;
  generate
    for (t = 0; t < NTYPE; t++) begin : g_cred
      wire gnt = fire && (gidx == 2'(t));
      // pend saturates so a burst of returns never wraps to a small count
      wire [CRED_W:0] sum = {1'b0, pend[t]} + {1'b0, add[t]};
      wire [CRED_W-1:0] next_pend = sum[CRED_W] ? '1 : sum[CRED_W-1:0];
      if (t < 2) begin : g_hdr
        // [R14] one credit per high cycle
        assign add[t] = {{(CRED_W-1){1'b0}}, header_credit_returned[t]};
      end else begin : g_dat
        wire [NUM_W-1:0] cnt = (t == 2) ? data_credit_return_count_p
                                        : data_credit_return_count_np;
        // [R16] count taken on strobe cycle
        assign add[t] = data_credit_return_strobe[t-2] ? {4'h0, cnt} : '0;
      end
      // [R15] timer expiry or threshold reached
      assign req[t] = full_req[t] || (tmr[t] >= upd_limit)
                      || (pend[t] != '0 && pend[t] >= {4'h0, thresh});
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pend[t]     <= '0;
          tmr[t]      <= '0;
          full_q[t]   <= 1'b0;
          full_req[t] <= 1'b0;
        end else if (ce) begin
          full_q[t]   <= user_buffer_full[t];
          // [R13] full edge requests early update
          full_req[t] <= (user_buffer_full[t] & ~full_q[t]) | (full_req[t] & ~gnt);
          pend[t]     <= gnt ? add[t] : next_pend;
          // timer stops at the limit so a late grant still sees the expiry
          tmr[t]      <= gnt ? '0 : (tmr[t] >= upd_limit ? tmr[t] : tmr[t] + 1'b1);
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      updfc_valid   <= 1'b0;
      updfc_type    <= TY_PH;
      updfc_credits <= '0;
    end else if (ce) begin
      updfc_valid   <= fire;
      // credits shown are the count held just before the grant cleared it
      if (fire) begin
        updfc_type    <= gidx;
        updfc_credits <= pend[gidx];
      end
    end
  end

  // ---------------- interrupts ----------------
  logic [STAT_W-1:0]    ev;
  assign ev[ST_MALF] = last & next_malf;
  assign ev[ST_ECRC] = last & next_ecrc;
  assign ev[ST_UR]   = last & next_ur;
  // [R11] user non-posted unsupported report
  assign ev[ST_UNP]  = user_unsupported_nonposted;
  // [R12] user posted unsupported report
  assign ev[ST_UP]   = user_unsupported_posted;
  assign ev[ST_UFC]  = fire;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat <= '0;
      irq  <= 1'b0;
    end else if (ce) begin
      // set wins over write-one-to-clear
      stat <= (stat & ~w1c) | ev;
      irq  <= |(stat & mask);
    end
  end

endmodule : pcierx_core

/* File: verilog/pcierx_pkg.sv */
// Purpose: shared constants of the receive TLP and credit return block
// Assumes: 64-bit receive path, four credit types, AHB-Lite register window
// Notes:   offsets are byte addresses of aligned 32-bit words
package pcierx_pkg;

  localparam int unsigned DATA_W = 64;
  localparam int unsigned BAR_W  = 7;
  localparam int unsigned CRED_W = 12;
  localparam int unsigned NUM_W  = 8;
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned NTYPE  = 4;
  localparam int unsigned STAT_W = 6;
  localparam int unsigned CTRL_W = 4;

  // credit type index
  localparam logic [1:0] TY_PH  = 2'h0;
  localparam logic [1:0] TY_NPH = 2'h1;
  localparam logic [1:0] TY_PD  = 2'h2;
  localparam logic [1:0] TY_NPD = 2'h3;

  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STAT   = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_TIMER  = 8'h0C;
  localparam logic [7:0] OFF_THRESH = 8'h10;
  localparam logic [7:0] OFF_HCRED  = 8'h14;
  localparam logic [7:0] OFF_DCRED  = 8'h18;

  // control fields
  localparam int unsigned CTRL_ECRC_BIT  = 0;
  localparam int unsigned CTRL_BAR64_LSB = 1;

  // status / mask bits
  localparam int unsigned ST_MALF = 0;
  localparam int unsigned ST_ECRC = 1;
  localparam int unsigned ST_UR   = 2;
  localparam int unsigned ST_UNP  = 3;
  localparam int unsigned ST_UP   = 4;
  localparam int unsigned ST_UFC  = 5;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RST   = 6'h00;
  localparam logic [TMR_W-1:0]  TIMER_RST  = 16'h0400;
  localparam logic [NUM_W-1:0]  THRESH_RST = 8'h08;

endpackage : pcierx_pkg

/* File: bench/pcierx_checker.sv */
// Purpose: port assertions for the receive stream and UpdateFC request
// Assumes: one clock domain; ce held high by the bench
// Notes:   bound to pcierx_core below
`timescale 1ns/1ps
module pcierx_checker
  import pcierx_pkg::*;
(
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              ce,
  // link stream
  input wire logic              lnk_valid,
  input wire logic              lnk_sop,
  input wire logic              lnk_eop,
  input wire logic [DATA_W-1:0] lnk_data,
  input wire logic              lnk_malformed,
  input wire logic              lnk_locked_read,
  // user side
  input wire logic              rx_packet_first_beat,
  input wire logic              rx_packet_last_beat,
  input wire logic [DATA_W-1:0] rx_payload_bus,
  input wire logic              rx_unsupported_flag,
  input wire logic              rx_malformed_flag,
  input wire logic [BAR_W-1:0]  rx_bar_hit,
  input wire logic [NTYPE-1:0]  user_buffer_full,
  input wire logic              updfc_valid,
  input wire logic [1:0]        updfc_type
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = ce && lnk_valid;
  first_beat_a: assert property (take && lnk_sop |=> rx_packet_first_beat)
    else $error("first beat flag missing");
  last_beat_a: assert property (take && lnk_eop |=> rx_packet_last_beat)
    else $error("last beat flag missing");
  byte_order_a: assert property (take |=> rx_payload_bus == $past(lnk_data))
    else $error("payload lanes differ");
  locked_ur_a: assert property (take && lnk_locked_read |=> rx_unsupported_flag)
    else $error("unsupported flag missing");
  malformed_a: assert property (take && lnk_malformed |=> rx_malformed_flag)
    else $error("malformed flag missing");
  bar_change_a: assert property ($changed(rx_bar_hit) |-> rx_packet_first_beat)
    else $error("hit vector moved mid packet");
  flag_hold_a: assert property ($fell(rx_malformed_flag) |-> rx_packet_first_beat)
    else $error("malformed flag dropped mid packet");
  full_fc_a: assert property ($rose(user_buffer_full[1]) |->
    ##[1:6] (updfc_valid && updfc_type == TY_NPH))
    else $error("no early UpdateFC on full");
endmodule : pcierx_checker

bind pcierx_core pcierx_checker u_pcierx_checker (
  .hclk, .hresetn, .ce, .lnk_valid, .lnk_sop, .lnk_eop, .lnk_data, .lnk_malformed,
  .lnk_locked_read, .rx_packet_first_beat, .rx_packet_last_beat, .rx_payload_bus,
  .rx_unsupported_flag, .rx_malformed_flag, .rx_bar_hit, .user_buffer_full,
  .updfc_valid, .updfc_type);

/* File: bench/pcierx_user_model.sv */
// Purpose: user logic consuming received packets
// Assumes: runs on hclk beside the core
// Notes:   one posted header credit back per packet
`timescale 1ns/1ps
module pcierx_user_model (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // receive side
  input  wire logic rx_packet_last_beat,
  input  wire logic rx_unsupported_flag,
  // credit and error return
  output logic      ph_cr,
  output logic      ur_np
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_cr <= 1'b0;
      ur_np <= 1'b0;
    end else begin
      ph_cr <= rx_packet_last_beat;
      ur_np <= rx_packet_last_beat && rx_unsupported_flag;
    end
  end
endmodule : pcierx_user_model

/* File: bench/pcierx_core_tb.sv */
// Purpose: self-checking bench for pcierx_core
// Assumes: zero wait AHB-Lite slave, ce high
// Notes:   timer set long except in its own check
`timescale 1ns/1ps
module pcierx_core_tb;
  import pcierx_pkg::*;
  logic        hclk, hresetn, hwrite, lnk_valid, lnk_sop, lnk_eop, lnk_dwen, up_ur;
  logic        lnk_ecrc_bad, lnk_malformed, lnk_locked_read, ph_cr, ur_np, hreadyout;
  logic        irq, rx_beat_valid, rx_packet_first_beat, rx_packet_last_beat;
  logic        rx_upper_half_only, rx_end_to_end_crc_fail, rx_unsupported_flag;
  logic        rx_malformed_flag, updfc_valid, hresp;
  logic [1:0]  htrans, data_credit_return_strobe, updfc_type;
  logic [31:0] haddr, hwdata, hrdata;
  logic [63:0] lnk_data, rx_payload_bus;
  logic [6:0]  lnk_bar_hit, rx_bar_hit;
  logic [3:0]  user_buffer_full;
  logic [7:0]  data_credit_return_count_p, data_credit_return_count_np;
  logic [11:0] updfc_credits;
  int          failures, checks_done;

  pcierx_core u_pcierx_core (
    .hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .lnk_valid,
    .lnk_sop, .lnk_eop, .lnk_dwen, .lnk_data, .lnk_ecrc_bad, .lnk_malformed,
    .lnk_locked_read, .lnk_bar_hit, .rx_beat_valid, .rx_packet_first_beat,
    .rx_packet_last_beat, .rx_upper_half_only, .rx_payload_bus,
    .rx_end_to_end_crc_fail, .rx_unsupported_flag, .rx_malformed_flag, .rx_bar_hit,
    .user_unsupported_nonposted(ur_np), .user_unsupported_posted(up_ur),
    .user_buffer_full, .header_credit_returned({1'b0, ph_cr}),
    .data_credit_return_strobe, .data_credit_return_count_p,
    .data_credit_return_count_np, .updfc_valid, .updfc_type, .updfc_credits);
  pcierx_user_model u_pcierx_user_model (
    .hclk, .hresetn, .rx_packet_last_beat, .rx_unsupported_flag, .ph_cr, .ur_np);

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      if (++n > 50) begin
        failures++;
        tally_and_finish;
      end
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask : ahb
  task automatic beat(input logic s, e, w, input logic [2:0] f, input logic [6:0] b,
                      input logic [63:0] d);
    @(posedge hclk);
    lnk_valid <= 1'b1;
    {lnk_sop, lnk_eop, lnk_dwen} <= {s, e, w};
    {lnk_ecrc_bad, lnk_malformed, lnk_locked_read} <= f;
    lnk_bar_hit <= b;
    lnk_data <= d;
  endtask : beat
  task automatic idle;
    @(posedge hclk);
    lnk_valid <= 1'b0;
    #1;
  endtask : idle
  task automatic wait_fc(input logic [1:0] t, input logic [11:0] c);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      if (++n > 200) begin
        failures++;
        tally_and_finish;
      end
    end while (!(updfc_valid === 1'b1 && updfc_type === t));
    chk("updfc_credits", c, updfc_credits);
  endtask : wait_fc

  task automatic t_reg;
    logic [31:0] q;
    ahb(0, OFF_TIMER, 0, q);
    chk("timer", TIMER_RST, q);
    chk("hresp", 0, hresp);
    ahb(0, OFF_THRESH, 0, q);
    chk("thresh", THRESH_RST, q);
    ahb(0, 8'h1C, 0, q);
    chk("unmapped", 0, q);
    ahb(1, OFF_TIMER, 32'hFFFF, q);
    ahb(0, OFF_TIMER, 0, q);
    chk("timer", 32'hFFFF, q);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_cred;
    logic [31:0] q;
    ahb(1, OFF_THRESH, 32'h2, q);
    beat(1, 1, 0, 3'h0, 7'h00, 64'h0);
    beat(1, 1, 0, 3'h0, 7'h00, 64'h0);
    idle;
    wait_fc(TY_PH, 12'h002);
    @(posedge hclk);
    data_credit_return_strobe <= 2'h3;
    data_credit_return_count_p <= 8'h05;
    data_credit_return_count_np <= 8'h03;
    @(posedge hclk);
    data_credit_return_strobe <= 2'h0;
    wait_fc(TY_PD, 12'h005);
    wait_fc(TY_NPD, 12'h003);
    @(posedge hclk);
    user_buffer_full <= 4'h2;
    wait_fc(TY_NPH, 12'h000);
    @(posedge hclk);
    user_buffer_full <= 4'h0;
    ahb(1, OFF_TIMER, 32'h10, q);
    wait_fc(TY_PH, 12'h000);
    ahb(1, OFF_TIMER, 32'hFFFF, q);
    $display("t_cred done");
  endtask : t_cred
  task automatic t_rx;
    logic [31:0] q;
    beat(1, 0, 0, 3'h0, 7'h44, 64'h0011223344556677);
    beat(0, 1, 1, 3'h4, 7'h00, 64'h8899AABBCCDDEEFF);
    #1;
    chk("first", 1, rx_packet_first_beat);
    chk("payload", 64'h0011223344556677, rx_payload_bus);
    chk("bar", 7'h44, rx_bar_hit);
    idle;
    chk("last", 1, rx_packet_last_beat);
    chk("half", 1, rx_upper_half_only);
    chk("bar held", 7'h44, rx_bar_hit);
    chk("crc off", 0, rx_end_to_end_crc_fail);
    ahb(1, OFF_CTRL, 32'h2, q);
    beat(1, 1, 0, 3'h0, 7'h02, 64'h0);
    idle;
    chk("bar pair", 7'h01, rx_bar_hit);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_err;
    logic [31:0] q;
    ahb(1, OFF_CTRL, 32'h1, q);
    ahb(1, OFF_MASK, 32'h4, q);
    beat(1, 0, 0, 3'h3, 7'h01, 64'h1);
    beat(0, 1, 0, 3'h4, 7'h01, 64'h2);
    idle;
    chk("forwarded", 1, rx_beat_valid);
    chk("unsupported", 1, rx_unsupported_flag);
    chk("malformed", 1, rx_malformed_flag);
    chk("crc fail", 1, rx_end_to_end_crc_fail);
    @(posedge hclk);
    up_ur <= 1'b1;
    @(posedge hclk);
    up_ur <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk("irq", 1, irq);
    ahb(0, OFF_STAT, 0, q);
    chk("stat", 32'h1F, q & 32'h1F);
    ahb(1, OFF_MASK, 32'h0, q);
    repeat (2) @(posedge hclk);
    chk("irq masked", 0, irq);
    ahb(1, OFF_STAT, 32'h3F, q);
    ahb(1, OFF_MASK, 32'h4, q);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 0, irq);
    beat(1, 1, 0, 3'h0, 7'h00, 64'h3);
    idle;
    chk("malformed restart", 0, rx_malformed_flag);
    chk("crc restart", 0, rx_end_to_end_crc_fail);
    chk("unsupported restart", 0, rx_unsupported_flag);
    $display("t_err done");
  endtask : t_err

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hwrite, lnk_valid, lnk_sop, lnk_eop, lnk_dwen, up_ur} = '0;
    {lnk_ecrc_bad, lnk_malformed, lnk_locked_read, htrans, haddr, hwdata} = '0;
    {lnk_data, lnk_bar_hit, user_buffer_full, data_credit_return_strobe} = '0;
    {data_credit_return_count_p, data_credit_return_count_np} = '0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reg;
    t_cred;
    t_rx;
    t_err;
    tally_and_finish;
  end
endmodule : pcierx_core_tb
